/* File: pkg/mmd_pkg.sv */
// constants and types shared by the memory map decoder
package mmd_pkg;

	// register indices inside the 64-byte block, and their bus byte addresses
	localparam logic [15:0] IDX_PRIO     = 16'h103c;
	localparam logic [15:0] IDX_REMAP    = 16'h103d;
	localparam logic [15:0] IDX_CONFIG   = 16'h103f;
	localparam logic [15:0] ADDR_PRIO    = {IDX_PRIO[13:0], 2'b00};
	localparam logic [15:0] ADDR_REMAP   = {IDX_REMAP[13:0], 2'b00};
	localparam logic [15:0] ADDR_CONFIG  = {IDX_CONFIG[13:0], 2'b00};

	// memory map
	localparam int          RAM_BYTES    = 512;
	localparam int          RAM_AW       = 9;
	localparam logic [7:0]  BOOT_PAGE    = 8'hbf;
	localparam logic [1:0]  EPROM_TOP    = 2'b11;
	localparam logic [15:0] EEPROM_LO    = 16'hb600;
	localparam logic [15:0] EEPROM_HI    = 16'hb7ff;

	// priority_and_mode fields
	localparam int          PRIO_BOOT    = 7;
	localparam int          PRIO_SMOD    = 6;
	localparam int          PRIO_MDA     = 5;
	localparam int          PRIO_IRVNE   = 4;
	localparam logic [3:0]  PSEL_RESET   = 4'h5;

	// ram_io_remap fields and reset value (ram page high nibble, register page low)
	localparam int          REMAP_RAM_LSB = 4;
	localparam int          REMAP_REG_LSB = 0;
	localparam logic [7:0]  REMAP_RESET   = 8'h01;

	// system_configuration fields
	localparam int          CFG_EPROM_MAP_ENABLE     = 1;
	localparam int          CFG_EEPROM_MAP_ENABLE     = 0;
	localparam logic [3:0]  CFG_UPPER    = 4'h0;

	// write protection window, in bus cycles after reset
	localparam int          PROTECT_CYCLES = 64;

	// axi responses
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	typedef struct packed {
		logic reg_blk;
		logic ram;
		logic boot_rom;
		logic eeprom;
		logic eprom;
		logic ext;
	} mmd_sel_t;

endpackage

/* File: logic/mmd_ram.sv */
// static ram, 512 bytes, registered read
module mmd_ram
	import mmd_pkg::*;
(
	// clock
	input  wire logic                core_clk,
	// access
	input  wire logic                en,
	input  wire logic                we,
	input  wire logic [RAM_AW-1:0]   addr,
	input  wire logic [7:0]          wdata,
	output logic      [7:0]          rdata
);

	logic [7:0] mem [RAM_BYTES];

	// no reset on the array: contents survive everything but power loss
	always_ff @(posedge core_clk) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (en && !we) begin
			rdata <= mem[addr];
		end
	end

endmodule

/* File: logic/mmd_guard.sv */
// protection window timer after reset
module mmd_guard
	import mmd_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// halt freezes the count
	input  wire logic halt,
	// window state
	output logic      window_open
);

	logic [6:0] count_reg;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			count_reg <= 7'h00;
		end else if (!halt && window_open) begin
			count_reg <= count_reg + 7'h01;
		end
	end

	assign window_open = (count_reg < 7'(PROTECT_CYCLES));

endmodule

/* File: logic/mmd_decoder.sv */
// memory map decoder with mode, remap and configuration registers
module mmd_decoder
	import mmd_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// straps and nonvolatile config, sampled after reset
	input  wire logic        mode_a,
	input  wire logic        mode_b,
	input  wire logic [7:0]  config_nv,
	// stop state
	input  wire logic        stop_mode,
	// cpu internal bus
	input  wire logic        cpu_valid,
	input  wire logic        cpu_we,
	input  wire logic [15:0] cpu_addr,
	input  wire logic [7:0]  cpu_wdata,
	output logic      [7:0]  cpu_rdata,
	// selects and read data from other resources
	output mmd_sel_t         sel,
	input  wire logic [7:0]  mem_rdata,
	// mode outputs
	output logic             special_mode,
	output logic             expanded_mode,
	output logic             read_visibility,
	output logic      [3:0]  prio_select,
	// axi4-lite slave
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// mode and configuration state
	logic       boot_rom_select_reg;
	logic       smod_reg;
	logic       mda_reg;
	logic       irvne_reg;
	logic [3:0] psel_reg;
	logic [7:0] remap_reg;
	logic       remap_done_reg;
	logic       eprom_map_enable_reg;
	logic       eeprom_map_enable_reg;
	logic       strap_pending_reg;
	logic       window_open;

	// unified register write port
	logic       wr_en;
	logic [5:0] wr_off;
	logic [7:0] wr_data;

	// decode
	logic       hit_reg;
	logic       hit_ram;
	logic       hit_boot;
	logic       hit_eeprom;
	logic       hit_eprom;
	logic       eprom_on;
	logic       access;

	// read path
	mmd_sel_t   sel_q_reg;
	logic [7:0] local_q_reg;
	logic       local_hit_q_reg;
	logic [7:0] mem_q_reg;
	logic [7:0] ram_rdata;

	// axi
	logic       aw_take;
	logic       ar_take;
	logic [5:0] aw_off;
	logic [5:0] ar_off;
	logic       aw_ok;
	logic       ar_ok;
	logic [7:0] ar_value;

	localparam logic [5:0] OFF_PRIO   = IDX_PRIO[5:0];
	localparam logic [5:0] OFF_REMAP  = IDX_REMAP[5:0];
	localparam logic [5:0] OFF_CONFIG = IDX_CONFIG[5:0];

	function automatic logic [7:0] reg_value(input logic [5:0] off,
		input logic [7:0] prio, input logic [7:0] remap, input logic [7:0] cfg);
		logic [7:0] v;
		v = 8'h00;
		if (off == OFF_PRIO) begin
			v = prio;
		end else if (off == OFF_REMAP) begin
			v = remap;
		end else if (off == OFF_CONFIG) begin
			v = cfg;
		end
		return v;
	endfunction

	logic [7:0] prio_value;
	logic [7:0] cfg_value;
	assign prio_value = {boot_rom_select_reg, smod_reg, mda_reg, irvne_reg, psel_reg};
	assign cfg_value  = {CFG_UPPER, 2'b00, eprom_map_enable_reg, eeprom_map_enable_reg};

	// window closes a fixed count of bus cycles after reset; stop freezes it
	mmd_guard u_guard (
		.core_clk    (core_clk),
		.reset       (reset),
		.halt        (stop_mode),
		.window_open (window_open)
	);

	// ---------------------------------------------------------------- decode
	// stop halts cpu bus activity, but the axi side keeps running; no cpu access is decoded while stopped
	assign access = cpu_valid && !stop_mode && !strap_pending_reg;

	// single-chip and bootstrap (mda clear) force the eprom on
	assign eprom_on = eprom_map_enable_reg || !mda_reg;

	always_comb begin
		hit_reg    = cpu_addr[15:12] == remap_reg[REMAP_REG_LSB +: 4]
			&& cpu_addr[11:6] == 6'h00;
		// default remap places ram at page zero, so direct addressing reaches it
		hit_ram    = cpu_addr[15:12] == remap_reg[REMAP_RAM_LSB +: 4]
			&& cpu_addr[11:9] == 3'h0;
		hit_boot   = boot_rom_select_reg && cpu_addr[15:8] == BOOT_PAGE;
		hit_eeprom = eeprom_map_enable_reg && cpu_addr >= EEPROM_LO
			&& cpu_addr <= EEPROM_HI;
		hit_eprom  = eprom_on && cpu_addr[15:14] == EPROM_TOP;
	end

	always_comb begin
		sel = '0;
		if (access) begin
			if (hit_reg) begin
				sel.reg_blk = 1'b1;
			end else if (hit_ram) begin
				sel.ram = 1'b1;
			end else if (hit_boot) begin
				sel.boot_rom = 1'b1;
			end else if (hit_eeprom) begin
				sel.eeprom = 1'b1;
			end else if (hit_eprom) begin
				sel.eprom = 1'b1;
			end else begin
				// a disabled eprom range falls here too
				sel.ext = mda_reg;
			end
		end
	end

	// ---------------------------------------------------------------- ram
	mmd_ram u_ram (
		.core_clk (core_clk),
		.en       (sel.ram),
		.we       (cpu_we),
		.addr     (cpu_addr[RAM_AW-1:0]),
		.wdata    (cpu_wdata),
		.rdata    (ram_rdata)
	);

	// ---------------------------------------------------------------- read path
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sel_q_reg       <= '0;
			local_q_reg     <= 8'h00;
			local_hit_q_reg <= 1'b0;
			mem_q_reg       <= 8'h00;
		end else begin
			sel_q_reg       <= sel;
			local_q_reg     <= reg_value(cpu_addr[5:0], prio_value, remap_reg, cfg_value);
			// other offsets of the block belong to peripherals outside
			local_hit_q_reg <= sel.reg_blk && (cpu_addr[5:0] == OFF_PRIO
				|| cpu_addr[5:0] == OFF_REMAP || cpu_addr[5:0] == OFF_CONFIG);
			mem_q_reg       <= mem_rdata;
		end
	end

	// all internal sources answer one cycle after the access
	always_comb begin
		cpu_rdata = mem_q_reg;
		if (local_hit_q_reg) begin
			cpu_rdata = local_q_reg;
		end else if (sel_q_reg.ram) begin
			cpu_rdata = ram_rdata;
		end
	end

	// ---------------------------------------------------------------- writes
	// cpu has priority; the axi side waits while the cpu writes registers
	logic cpu_reg_wr;
	assign cpu_reg_wr = sel.reg_blk && cpu_we;

	always_comb begin
		wr_en   = 1'b0;
		wr_off  = 6'h00;
		wr_data = 8'h00;
		if (cpu_reg_wr) begin
			wr_en   = 1'b1;
			wr_off  = cpu_addr[5:0];
			wr_data = cpu_wdata;
		end else if (aw_take && aw_ok && s_axi_wstrb[0]) begin
			wr_en   = 1'b1;
			wr_off  = aw_off;
			wr_data = s_axi_wdata[7:0];
		end
	end

	// straps caught on the first edge after release
	always_ff @(posedge core_clk) begin
		if (reset) begin
			strap_pending_reg <= 1'b1;
		end else begin
			strap_pending_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			boot_rom_select_reg <= 1'b0;
			smod_reg            <= 1'b0;
			mda_reg             <= 1'b0;
			irvne_reg           <= 1'b0;
			psel_reg            <= PSEL_RESET;
		end else if (strap_pending_reg) begin
			boot_rom_select_reg <= !mode_b && !mode_a;
			smod_reg            <= !mode_b;
			mda_reg             <= mode_a;
			irvne_reg           <= !mode_b && mode_a;
		end else if (wr_en && wr_off == OFF_PRIO) begin
			// boot rom leaves the map whenever smod drops
			boot_rom_select_reg <= smod_reg && wr_data[PRIO_SMOD] && wr_data[PRIO_BOOT];
			smod_reg            <= smod_reg && wr_data[PRIO_SMOD];
			if (smod_reg) begin
				mda_reg <= wr_data[PRIO_MDA];
			end
			irvne_reg           <= wr_data[PRIO_IRVNE];
			psel_reg            <= wr_data[3:0];
		end
	end

	// special modes may rewrite the remap at any time
	always_ff @(posedge core_clk) begin
		if (reset) begin
			remap_reg      <= REMAP_RESET;
			remap_done_reg <= 1'b0;
		end else if (wr_en && wr_off == OFF_REMAP
			&& ((window_open && !remap_done_reg) || smod_reg)) begin
			remap_reg      <= wr_data;
			remap_done_reg <= 1'b1;
		end
	end

	// latches load from the nonvolatile byte; only special modes rewrite them
	always_ff @(posedge core_clk) begin
		if (reset) begin
			eprom_map_enable_reg  <= 1'b0;
			eeprom_map_enable_reg <= 1'b0;
		end else if (strap_pending_reg) begin
			eprom_map_enable_reg  <= config_nv[CFG_EPROM_MAP_ENABLE];
			eeprom_map_enable_reg <= config_nv[CFG_EEPROM_MAP_ENABLE];
		end else if (wr_en && wr_off == OFF_CONFIG && smod_reg) begin
			eprom_map_enable_reg  <= wr_data[CFG_EPROM_MAP_ENABLE];
			eeprom_map_enable_reg <= wr_data[CFG_EEPROM_MAP_ENABLE];
		end
	end

	assign special_mode    = smod_reg;
	assign expanded_mode   = mda_reg;
	assign read_visibility = irvne_reg;
	assign prio_select     = psel_reg;

	// ---------------------------------------------------------------- axi4-lite
	function automatic logic addr_ok(input logic [15:0] a);
		return a == ADDR_PRIO || a == ADDR_REMAP || a == ADDR_CONFIG;
	endfunction

	assign aw_off  = s_axi_awaddr[7:2];
	assign aw_ok   = addr_ok(s_axi_awaddr);
	// nothing is taken before the straps settle, so no write is lost to them
	assign aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !cpu_reg_wr
		&& !strap_pending_reg;
	assign s_axi_awready = aw_take;
	assign s_axi_wready  = aw_take;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (aw_take) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= aw_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	assign ar_off   = s_axi_araddr[7:2];
	assign ar_ok    = addr_ok(s_axi_araddr);
	assign ar_take  = s_axi_arvalid && !s_axi_rvalid
		&& !strap_pending_reg;
	assign ar_value = reg_value(ar_off, prio_value, remap_reg, cfg_value);
	assign s_axi_arready = ar_take;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			// unmapped offsets read zero with an error
			s_axi_rdata  <= {24'h00_0000, ar_ok ? ar_value : 8'h00};
			s_axi_rresp  <= ar_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

/* File: tb/mmd_decoder_asserts.sv */
// concurrent checks on the memory map decoder ports
module mmd_decoder_asserts
	import mmd_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        reset,
	// cpu side
	input wire logic        stop_mode,
	input wire logic        cpu_valid,
	input wire logic        cpu_we,
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0]  cpu_rdata,
	input wire mmd_sel_t    sel,
	// mode outputs
	input wire logic        special_mode,
	input wire logic        expanded_mode,
	input wire logic        read_visibility,
	input wire logic [3:0]  prio_select
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic live;
	assign live = cpu_valid && !stop_mode;

	chk_sel_onehot: assert property ($onehot0(sel))
		else $error("more than one select");
	chk_stop_quiet: assert property (stop_mode |-> sel == '0)
		else $error("select during stop");
	chk_idle_quiet: assert property (!cpu_valid |-> sel == '0)
		else $error("select without access");
	chk_boot_place: assert property (sel.boot_rom |-> special_mode && cpu_addr[15:8] == BOOT_PAGE)
		else $error("boot rom select misplaced");
	chk_eeprom_place: assert property (sel.eeprom |-> cpu_addr inside {[EEPROM_LO:EEPROM_HI]})
		else $error("eeprom select misplaced");
	chk_eprom_place: assert property (sel.eprom |-> cpu_addr[15:14] == EPROM_TOP)
		else $error("eprom select misplaced");
	chk_ext_expanded: assert property (sel.ext |-> expanded_mode && live)
		else $error("external select outside expanded mode");
	chk_eprom_forced: assert property (live && !$past(reset) && !expanded_mode
		&& cpu_addr[15:14] == EPROM_TOP |-> sel.eprom || sel.ram || sel.reg_blk)
		else $error("eprom not forced on");
	chk_prio_read: assert property (live && !cpu_we && sel.reg_blk
		&& cpu_addr[5:0] == IDX_PRIO[5:0] |=> cpu_rdata[6:0]
		== $past({special_mode, expanded_mode, read_visibility, prio_select}))
		else $error("register read lost to memory");

	cv_reg: cover property (live && sel.reg_blk);
	cv_boot: cover property (sel.boot_rom);
	cv_ext: cover property (sel.ext);
	cv_stop: cover property (stop_mode && cpu_valid);
endmodule

/* File: tb/mmd_cpu_model.sv */
// cpu core model issuing internal bus accesses
module mmd_cpu_model
	import mmd_pkg::*;
(
	// clock
	input  wire logic        core_clk,
	// bus to decoder
	output logic             cpu_valid,
	output logic             cpu_we,
	output logic      [15:0] cpu_addr,
	output logic      [7:0]  cpu_wdata,
	input  wire mmd_sel_t    sel,
	input  wire logic [7:0]  cpu_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cpu_valid = 1'b0;
		cpu_we = 1'b0;
		cpu_addr = 16'hffff;
		cpu_wdata = 8'h00;
	end
	// one access; idle address and data lines show the inverse of the last value
	task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d,
		output mmd_sel_t s, output logic [7:0] rd);
		@(posedge core_clk);
		cpu_valid <= 1'b1;
		cpu_we <= we;
		cpu_addr <= a;
		cpu_wdata <= d;
		@(negedge core_clk);
		s = sel;
		@(posedge core_clk);
		cpu_valid <= 1'b0;
		cpu_addr <= ~a;
		cpu_wdata <= ~d;
		@(negedge core_clk);
		rd = cpu_rdata;
	endtask
endmodule

/* File: tb/mmd_decoder_bench.sv */
// self-checking bench for the memory map decoder
module mmd_decoder_bench import mmd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0, reset = 1'b1, mode_a = 1'b0, mode_b = 1'b1, stop_mode = 1'b0;
	logic [7:0]  config_nv = 8'h00, mem_rdata = 8'h00, cpu_wdata, cpu_rdata;
	logic        cpu_valid, cpu_we, special_mode, expanded_mode, read_visibility;
	logic [15:0] cpu_addr, awaddr = 16'h0, araddr = 16'h0;
	logic [3:0]  prio_select, wstrb = 4'hf;
	mmd_sel_t    sel;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	int          fail_count = 0, checks_done = 0, cycles = 0;
	integer      seed = 32'hb259b634;
	logic [15:0] probes [14] = '{16'h1000, 16'h103c, 16'h103f, 16'h0000, 16'h01ff, 16'h0200,
		16'hbf00, 16'hbfff, 16'hb5ff, 16'hb600, 16'hb7ff, 16'hc000, 16'hffff, 16'h8000};
	logic [15:0] probes2 [6] = '{16'hc000, 16'hc03f, 16'hc040, 16'hc1ff, 16'hc200, 16'h0000};

	mmd_decoder dut (.core_clk(core_clk), .reset(reset), .mode_a(mode_a), .mode_b(mode_b),
		.config_nv(config_nv), .stop_mode(stop_mode), .cpu_valid(cpu_valid), .cpu_we(cpu_we),
		.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .sel(sel),
		.mem_rdata(mem_rdata), .special_mode(special_mode), .expanded_mode(expanded_mode),
		.read_visibility(read_visibility), .prio_select(prio_select),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	mmd_cpu_model cpu (.core_clk(core_clk), .cpu_valid(cpu_valid), .cpu_we(cpu_we),
		.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .sel(sel), .cpu_rdata(cpu_rdata));

	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		mem_rdata <= cycles[7:0] ^ 8'h5a;
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_sel(input mmd_sel_t got, input mmd_sel_t exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t select %b expected %b", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] exp_prio(input logic [1:0] m);
		return {m == 2'b00, !m[1], m[0], m == 2'b01, PSEL_RESET};
	endfunction
	function automatic mmd_sel_t exp_sel(input logic [1:0] m, input logic [7:0] c,
		input logic [7:0] rm, input logic [15:0] a);
		mmd_sel_t s = '0;
		if (a[15:12] == rm[3:0] && a[11:6] == 6'h0) s.reg_blk = 1'b1;
		else if (a[15:12] == rm[7:4] && a[11:9] == 3'h0) s.ram = 1'b1;
		else if (a[15:8] == BOOT_PAGE && m == 2'b00) s.boot_rom = 1'b1;
		else if (a >= EEPROM_LO && a <= EEPROM_HI && c[CFG_EEPROM_MAP_ENABLE]) s.eeprom = 1'b1;
		else if (a[15:14] == EPROM_TOP && (c[CFG_EPROM_MAP_ENABLE] || !m[0])) s.eprom = 1'b1;
		else if (m[0]) s.ext = 1'b1;
		return s;
	endfunction
	task automatic boot(input logic [1:0] m, input logic [7:0] c);
		@(posedge core_clk);
		reset <= 1'b1;
		mode_b <= m[1];
		mode_a <= m[0];
		config_nv <= c;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic axi_wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge core_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		while (!bvalid) @(posedge core_clk);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [15:0] a, output logic [7:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge core_clk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge core_clk);
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic probe(input logic [1:0] m, input logic [7:0] c, input logic [7:0] rm,
		input logic [15:0] a);
		mmd_sel_t   s;
		mmd_sel_t   x;
		logic [7:0] rd;
		x = exp_sel(m, c, rm, a);
		cpu.access(1'b0, a, 8'h00, s, rd);
		chk_sel(s, x);
		// outside sources answer one cycle after the access edge
		if (!x.ram && !x.reg_blk) chk8(rd, 8'(cycles - 2) ^ 8'h5a);
	endtask

	initial begin
		logic [1:0] r;
		logic [7:0] d, c, e;
		logic [7:0] img [16];
		mmd_sel_t   s;
		for (int i = 0; i < 8; i++) begin
			c = 8'($random(seed));
			c[1:0] = {i[2], i[2] ^ i[0]};
			e = exp_prio(i[1:0]);
			boot(i[1:0], c);
			axi_rd(ADDR_PRIO, d, r);
			chk8(d, e);
			chk8({5'h0, special_mode, expanded_mode, read_visibility}, {5'h0, e[6:4]});
			axi_rd(ADDR_CONFIG, d, r);
			chk8(d, {6'h0, c[CFG_EPROM_MAP_ENABLE], c[CFG_EEPROM_MAP_ENABLE]});
			foreach (probes[k]) probe(i[1:0], c, REMAP_RESET, probes[k]);
			probe(i[1:0], c, REMAP_RESET, 16'($random(seed)));
		end
		// overlap of registers, ram and eprom on one page
		boot(2'b10, 8'h00);
		axi_wr(ADDR_REMAP, 8'hcc, r);
		chk8({6'h0, r}, {6'h0, RESP_OKAY});
		foreach (probes2[k]) probe(2'b10, 8'h00, 8'hcc, probes2[k]);
		cpu.access(1'b0, {10'h300, IDX_REMAP[5:0]}, 8'h00, s, d);
		chk8(d, 8'hcc);
		axi_wr(ADDR_REMAP, 8'h00, r);
		axi_rd(ADDR_REMAP, d, r);
		chk8(d, 8'hcc);
		for (int k = 0; k < 16; k++) begin
			img[k] = 8'($random(seed));
			cpu.access(1'b1, {8'hc1, 4'(k), 4'h7}, img[k], s, d);
		end
		@(posedge core_clk);
		stop_mode <= 1'b1;
		cpu.access(1'b0, 16'hc107, 8'h00, s, d);
		chk_sel(s, '0);
		repeat (20) @(posedge core_clk);
		stop_mode <= 1'b0;
		for (int k = 0; k < 16; k++) begin
			cpu.access(1'b0, {8'hc1, 4'(k), 4'h7}, 8'h00, s, d);
			chk8(d, img[k]);
		end
		axi_rd(16'h0000, d, r);
		chk8({6'h0, r}, {6'h0, RESP_SLVERR});
		// bootstrap: rewrite latches, then leave special mode for expanded
		boot(2'b00, 8'h00);
		axi_wr(ADDR_CONFIG, 8'h01, r);
		axi_rd(ADDR_CONFIG, d, r);
		chk8(d, 8'h01);
		axi_wr(ADDR_PRIO, 8'ha3, r);
		axi_rd(ADDR_PRIO, d, r);
		chk8(d, 8'h23);
		axi_wr(ADDR_PRIO, 8'hc0, r);
		axi_rd(ADDR_PRIO, d, r);
		chk8(d, 8'h20);
		foreach (probes[k]) probe(2'b11, 8'h01, REMAP_RESET, probes[k]);
		// remap write after the protection window
		boot(2'b10, 8'h00);
		repeat (PROTECT_CYCLES + 8) @(posedge core_clk);
		axi_wr(ADDR_REMAP, 8'h22, r);
		axi_rd(ADDR_REMAP, d, r);
		chk8(d, REMAP_RESET);
		summarize();
	end
endmodule

bind mmd_decoder mmd_decoder_asserts u_chk (.core_clk(core_clk), .reset(reset),
	.stop_mode(stop_mode), .cpu_valid(cpu_valid), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
	.cpu_rdata(cpu_rdata), .sel(sel), .special_mode(special_mode),
	.expanded_mode(expanded_mode), .read_visibility(read_visibility),
	.prio_select(prio_select));
